// ===== hdl/slg_consts.vh
// offsets, field positions, reset values and bounds of the stack and secure ram guard
`ifndef SLG_CONSTS_VH
`define SLG_CONSTS_VH
`define SLG_OFF_SP 12'h000
`define SLG_OFF_LIMIT 12'h004
`define SLG_OFF_SEC_CTRL 12'h008
`define SLG_OFF_BOOT_RANGE 12'h00c
`define SLG_OFF_GEN_RANGE 12'h010
`define SLG_OFF_STATUS 12'h014
`define SLG_OFF_MASK 12'h018
`define SLG_OFF_STATE 12'h01c
`define SLG_BIT_BOOT_EN 0
`define SLG_BIT_GEN_EN 1
`define SLG_EV_OVERFLOW 0
`define SLG_EV_UNDERFLOW 1
`define SLG_EV_BOOT_DENY 2
`define SLG_EV_GEN_DENY 3
`define SLG_NUM_EV 4
`define SLG_SP_RESET 16'h0800
`define SLG_SP_FLOOR 16'h0800
`define SLG_WORD_STEP 16'h0002
`define SLG_RANGE_RESET 32'h0000_0000
`define SLG_KIND_DATA 2'h0
`define SLG_KIND_CALL_LO 2'h1
`define SLG_KIND_CALL_HI 2'h2
`define SLG_KIND_EXC_HI 2'h3
`endif

// ===== hdl/slg_seg_guard.v
// secure ram segment access check against the executing code segment
`timescale 1ns/10ps
module slg_seg_guard #(
	parameter AW = 16
) (
	// access from the address generators
	input wire acc_valid,
	input wire [AW-1:0] acc_addr,
	// executing code segment
	input wire exec_in_boot,
	input wire exec_in_secure,
	// segment setup
	input wire boot_en,
	input wire gen_en,
	input wire [2*AW-1:0] boot_range,
	input wire [2*AW-1:0] gen_range,
	// verdicts
	output wire boot_deny,
	output wire gen_deny
);
	// ranges are inclusive: low half is the first address, high half the last
	function in_range;
		input [AW-1:0] a;
		input [2*AW-1:0] r;
		begin
			in_range = (a >= r[AW-1:0]) && (a <= r[2*AW-1:AW]);
		end
	endfunction

	assign boot_deny = acc_valid && boot_en && in_range(acc_addr, boot_range) && !exec_in_boot;
	assign gen_deny = acc_valid && gen_en && in_range(acc_addr, gen_range) && !exec_in_secure;
endmodule // slg_seg_guard

// ===== hdl/slg_stack_guard.v
// stack pointer, stack limit checking, return word forming and secure ram guard with ahb-lite registers
`timescale 1ns/10ps
`include "slg_consts.vh"

// How it works
// - pointer names first free word, grows upward
// - push writes then increments; pop decrements then reads
// - call pushes upper pc byte zero-extended
// - exception pushes status low byte with upper pc
// - stack limit has no reset value
// - stack limit bit 0 always reads zero
// - push and pop addresses, and effective addresses in cycles with neither, checked against limit once software has written one
// - push at pointer equal limit gives no trap
// - next push beyond limit raises trap
// - push, pop or effective address below 0x0800 raises underflow trap
// - boot secure ram only from boot code
// - general secure ram only from secure code
module slg_stack_guard #(
	parameter AW = 16
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	// stack operations from the core
	input wire stk_push,
	input wire [1:0] stk_push_kind,
	input wire [15:0] stk_push_data,
	input wire [22:0] pc,
	input wire [7:0] status_low_byte,
	input wire ipl3_bit,
	input wire stk_pop,
	// other effective addresses formed from the stack pointer
	input wire sp_ea_valid,
	input wire [AW-1:0] sp_ea,
	// direct load of the stack pointer as a working register
	input wire sp_load,
	input wire [AW-1:0] sp_load_value,
	// secure ram access checking
	input wire acc_valid,
	input wire [AW-1:0] acc_addr,
	input wire exec_in_boot,
	input wire exec_in_secure,
	// stack memory access
	output wire mem_en,
	output wire mem_we,
	output wire [AW-1:0] mem_addr,
	output wire [15:0] mem_wdata,
	// pointer and traps
	output wire [AW-1:0] stack_pointer_register,
	output wire stack_trap,
	output wire boot_secure_ram_segment_deny,
	output wire general_secure_ram_segment_deny,
	output wire irq
);
	// register file
	reg [AW-1:0] sp_q;
	reg [AW-1:0] sp_d;
	reg [AW-1:0] limit_q;
	reg limit_set_q;
	reg [1:0] sec_ctrl_q;
	reg [2*AW-1:0] boot_range_q;
	reg [2*AW-1:0] gen_range_q;
	reg [`SLG_NUM_EV-1:0] status_q;
	reg [`SLG_NUM_EV-1:0] mask_q;
	reg trap_seen_q;

	// ahb data phase
	reg dp_valid_q;
	reg dp_write_q;
	reg [11:0] dp_addr_q;
	reg [31:0] rdata;

	// stack checking
	reg [AW-1:0] chk_addr;
	reg chk_valid;
	wire over_hit;
	wire under_hit;
	wire boot_hit;
	wire gen_hit;
	wire [`SLG_NUM_EV-1:0] ev;
	wire wr_sp;
	wire wr_limit;
	wire wr_status;
	wire wr_sec;
	wire wr_boot;
	wire wr_gen;
	wire wr_mask;
	wire [`SLG_NUM_EV-1:0] pending;
	reg [15:0] push_word;
	wire [AW-1:0] step;
	wire [AW-1:0] sp_dec;
	wire [7:0] pc_upper;

	// one stack word is two bytes
	assign step = `SLG_WORD_STEP;
	assign sp_dec = sp_q - step;
	// top bit kept clear so a call frame never carries status bits
	assign pc_upper = {1'b0, pc[22:16]};

	// decode of a latched register write, used by several registers
	function reg_wr;
		input v;
		input w;
		input [11:0] a;
		input [11:0] off;
		begin
			reg_wr = v && w && (a == off);
		end
	endfunction

	assign wr_sp = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_SP);
	assign wr_limit = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_LIMIT);
	assign wr_status = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_STATUS);
	assign wr_sec = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_SEC_CTRL);
	assign wr_boot = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_BOOT_RANGE);
	assign wr_gen = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_GEN_RANGE);
	assign wr_mask = reg_wr(dp_valid_q, dp_write_q, dp_addr_q, `SLG_OFF_MASK);

	// pointer and limit are word addresses, so bit 0 is dropped wherever they are loaded
	function [AW-1:0] word_align;
		input [AW-1:0] v;
		begin
			word_align = {v[AW-1:1], 1'b0};
		end
	endfunction

	// ahb-lite: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase is taken only while ready, so a held request is counted once
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= 12'h000;
		end else if (hready) begin
			dp_valid_q <= hsel && htrans[1];
			dp_write_q <= hwrite;
			dp_addr_q <= {haddr[11:2], 2'b00};
		end
	end

	// read mux looks at the latched data-phase address so a write just before a read is seen
	always @* begin
		rdata = 32'h0000_0000;
		if (dp_valid_q && !dp_write_q) begin
			case (dp_addr_q)
				`SLG_OFF_SP: rdata[AW-1:0] = sp_q;
				`SLG_OFF_LIMIT: rdata[AW-1:0] = word_align(limit_q);
				`SLG_OFF_SEC_CTRL: rdata[1:0] = sec_ctrl_q;
				`SLG_OFF_BOOT_RANGE: rdata[2*AW-1:0] = boot_range_q;
				`SLG_OFF_GEN_RANGE: rdata[2*AW-1:0] = gen_range_q;
				`SLG_OFF_STATUS: rdata[`SLG_NUM_EV-1:0] = status_q;
				`SLG_OFF_MASK: rdata[`SLG_NUM_EV-1:0] = mask_q;
				`SLG_OFF_STATE: rdata[1:0] = {trap_seen_q, limit_set_q};
				default: rdata = 32'h0000_0000;
			endcase
		end
	end
	// zero outside a read data phase, so the bus never sees stale register data
	assign hrdata = rdata;

	// stack pointer: core operations take priority over a bus write in the same cycle
	always @* begin
		sp_d = sp_q;
		if (stk_push) begin
			sp_d = sp_q + step;
		end else if (stk_pop) begin
			sp_d = sp_dec;
		end else if (sp_load) begin
			sp_d = word_align(sp_load_value);
		end else if (wr_sp) begin
			sp_d = word_align(hwdata[AW-1:0]);
		end
	end

	// reset leaves the pointer at the floor, the first legal stack word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sp_q <= `SLG_SP_RESET;
		end else begin
			sp_q <= sp_d;
		end
	end

	// limit has no reset so its content is unknown until written
	always @(posedge hclk) begin
		if (wr_limit) begin
			limit_q <= word_align(hwdata[AW-1:0]);
		end
	end

	// the new limit is used from the next cycle; an indirect stack read right after the write
	// may still be checked against the old limit
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit_set_q <= 1'b0;
		end else if (wr_limit) begin
			limit_set_q <= 1'b1;
		end
	end

	// other control registers, one process each so every flop has one decoded write
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_ctrl_q <= 2'h0;
		end else if (wr_sec) begin
			sec_ctrl_q <= hwdata[1:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_range_q <= `SLG_RANGE_RESET;
		end else if (wr_boot) begin
			boot_range_q <= hwdata[2*AW-1:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gen_range_q <= `SLG_RANGE_RESET;
		end else if (wr_gen) begin
			gen_range_q <= hwdata[2*AW-1:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= {`SLG_NUM_EV{1'b0}};
		end else if (wr_mask) begin
			mask_q <= hwdata[`SLG_NUM_EV-1:0];
		end
	end

	// address under check: push uses the pointer, pop the pre-decremented pointer
	always @* begin
		chk_valid = 1'b0;
		chk_addr = sp_q;
		if (stk_push) begin
			chk_valid = 1'b1;
			chk_addr = sp_q;
		end else if (stk_pop) begin
			chk_valid = 1'b1;
			chk_addr = sp_dec;
		end else if (sp_ea_valid) begin
			chk_valid = 1'b1;
			chk_addr = sp_ea;
		end
	end

	// equal to the limit is still legal, only beyond it traps; unchecked until software sets a limit
	assign over_hit = chk_valid && limit_set_q && (chk_addr > limit_q);
	assign under_hit = chk_valid && (chk_addr < `SLG_SP_FLOOR);
	assign stack_trap = over_hit || under_hit;

	// stack memory port
	assign mem_en = stk_push || stk_pop;
	assign mem_we = stk_push;
	// a push wins over a same-cycle pop, so only a lone pop uses the decremented pointer
	assign mem_addr = (stk_pop && !stk_push) ? sp_dec : sp_q;
	// the pushed word; the kind only matters while a push is on
	always @* begin
		push_word = stk_push_data;
		case (stk_push_kind)
			`SLG_KIND_DATA: push_word = stk_push_data;
			`SLG_KIND_CALL_LO: push_word = pc[15:0];
			`SLG_KIND_CALL_HI: push_word = {8'h00, pc_upper};
			`SLG_KIND_EXC_HI: push_word = {status_low_byte, ipl3_bit, pc[22:16]};
			default: push_word = stk_push_data;
		endcase
	end
	assign mem_wdata = push_word;
	assign stack_pointer_register = sp_q;

	// secure ram segments
	// the guard only flags; blocking the access is up to whoever takes the deny pulse
	slg_seg_guard #(
		.AW(AW)
	) u_seg (
		.acc_valid(acc_valid),
		.acc_addr(acc_addr),
		.exec_in_boot(exec_in_boot),
		.exec_in_secure(exec_in_secure),
		.boot_en(sec_ctrl_q[`SLG_BIT_BOOT_EN]),
		.gen_en(sec_ctrl_q[`SLG_BIT_GEN_EN]),
		.boot_range(boot_range_q),
		.gen_range(gen_range_q),
		.boot_deny(boot_hit),
		.gen_deny(gen_hit)
	);
	assign boot_secure_ram_segment_deny = boot_hit;
	assign general_secure_ram_segment_deny = gen_hit;

	// sticky events, write one to clear; a new event in the clearing cycle wins
	assign ev[`SLG_EV_OVERFLOW] = over_hit;
	assign ev[`SLG_EV_UNDERFLOW] = under_hit;
	assign ev[`SLG_EV_BOOT_DENY] = boot_hit;
	assign ev[`SLG_EV_GEN_DENY] = gen_hit;

	genvar gi;
	generate
		for (gi = 0; gi < `SLG_NUM_EV; gi = gi + 1) begin : g_ev
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					status_q[gi] <= 1'b0;
				end else if (ev[gi]) begin
					status_q[gi] <= 1'b1;
				end else if (wr_status && hwdata[gi]) begin
					status_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// sticky summary for software, only reset clears it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trap_seen_q <= 1'b0;
		end else if (stack_trap) begin
			trap_seen_q <= 1'b1;
		end
	end

	// level output: clearing the status bit or its mask bit drops it
	assign pending = status_q & mask_q;
	assign irq = |pending;
endmodule // slg_stack_guard

// ===== testbench/slg_guard_checker.sv
// assertions on the stack and secure ram guard ports
`timescale 1ns/10ps
module slg_guard_checker (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// core side
	input wire stk_push,
	input wire [1:0] stk_push_kind,
	input wire [22:0] pc,
	input wire [7:0] status_low_byte,
	input wire ipl3_bit,
	input wire stk_pop,
	input wire sp_ea_valid,
	input wire [15:0] sp_ea,
	input wire acc_valid,
	input wire exec_in_boot,
	input wire exec_in_secure,
	// outputs
	input wire mem_we,
	input wire [15:0] mem_addr,
	input wire [15:0] mem_wdata,
	input wire [15:0] stack_pointer_register,
	input wire stack_trap,
	input wire boot_secure_ram_segment_deny,
	input wire general_secure_ram_segment_deny
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_push_at_sp: assert property (stk_push |-> mem_we && mem_addr == stack_pointer_register)
		else $error("push address");
	a_pop_first: assert property (stk_pop && !stk_push |-> mem_addr == stack_pointer_register - 16'h0002
		##1 stack_pointer_register == $past(mem_addr)) else $error("pop order");
	a_call_high: assert property (stk_push && stk_push_kind == 2'h2 |-> mem_wdata == {9'h0, pc[22:16]})
		else $error("call word");
	a_exc_high: assert property (stk_push && stk_push_kind == 2'h3
		|-> mem_wdata == {status_low_byte, ipl3_bit, pc[22:16]}) else $error("exception word");
	a_sp_floor: assert property (stk_push && stack_pointer_register < 16'h0800 |-> stack_trap)
		else $error("underflow");
	a_ea_checked: assert property (sp_ea_valid && !stk_push && !stk_pop && sp_ea < 16'h0800 |-> stack_trap)
		else $error("ea check");
	a_boot_only: assert property (boot_secure_ram_segment_deny |-> acc_valid && !exec_in_boot)
		else $error("boot deny");
	a_gen_only: assert property (general_secure_ram_segment_deny |-> acc_valid && !exec_in_secure)
		else $error("general deny");
	a_trap_cause: assert property (stack_trap |-> stk_push || stk_pop || sp_ea_valid)
		else $error("trap without stack address");
endmodule // slg_guard_checker

// ===== testbench/slg_core_model.sv
// core model issuing stack operations and secure ram accesses
`timescale 1ns/10ps
module slg_core_model (
	// clock
	input wire hclk,
	// strobes and operands
	output reg stk_push = 0,
	output reg [1:0] stk_push_kind = 0,
	output reg [15:0] stk_push_data = 0,
	output reg stk_pop = 0,
	output reg sp_ea_valid = 0,
	output reg [15:0] sp_ea = 0,
	output reg sp_load = 0,
	output reg [15:0] sp_load_value = 0,
	output reg acc_valid = 0,
	output reg [15:0] acc_addr = 0
);
	// codes 0-3 push kinds, 4 pop, 5 stack address, 6 secure access, 7 pointer load
	task automatic op(input [2:0] c, input [15:0] v);
		@(posedge hclk);
		stk_push <= (c < 3'h4);
		stk_push_kind <= c[1:0];
		stk_pop <= (c == 3'h4);
		sp_ea_valid <= (c == 3'h5);
		acc_valid <= (c == 3'h6);
		sp_load <= (c == 3'h7);
		{stk_push_data, sp_ea, acc_addr, sp_load_value} <= {4{v}};
		@(posedge hclk);
		{stk_push, stk_pop, sp_ea_valid, acc_valid, sp_load} <= 5'h0;
		// idle operands scrambled so a stale value never looks live
		{stk_push_data, sp_ea, acc_addr, sp_load_value} <= {$urandom, $urandom};
	endtask
endmodule // slg_core_model

// ===== testbench/slg_stack_guard_test.sv
// self-checking bench for the stack and secure ram guard
`timescale 1ns/10ps
module slg_stack_guard_test;
	reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ipl3_bit = 0, exec_in_boot = 0, exec_in_secure = 0;
	reg [31:0] haddr = 0, hwdata = 0;
	reg [1:0] htrans = 0;
	reg [22:0] pc = 0;
	reg [7:0] status_low_byte = 0;
	reg [15:0] sp = 16'h0800, lim = 0;
	reg lim_set = 0, rd_ph = 0;
	integer n_mismatch = 0, compares = 0, i;
	logic [34:0] evq[$], rdq[$];
	wire hreadyout, hresp, mem_en, mem_we, stack_trap, irq, stk_push, stk_pop, sp_ea_valid, acc_valid, sp_load;
	wire boot_secure_ram_segment_deny, general_secure_ram_segment_deny;
	wire [31:0] hrdata;
	wire [1:0] stk_push_kind;
	wire [15:0] mem_addr, mem_wdata, stack_pointer_register, sp_ea, acc_addr, sp_load_value, stk_push_data;
	slg_stack_guard i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .stk_push, .stk_push_kind, .stk_push_data, .pc, .status_low_byte, .ipl3_bit,
		.stk_pop, .sp_ea_valid, .sp_ea, .sp_load, .sp_load_value, .acc_valid, .acc_addr, .exec_in_boot, .exec_in_secure,
		.mem_en, .mem_we, .mem_addr, .mem_wdata, .stack_pointer_register, .stack_trap, .boot_secure_ram_segment_deny,
		.general_secure_ram_segment_deny, .irq);
	slg_core_model i_core (.hclk, .stk_push, .stk_push_kind, .stk_push_data, .stk_pop, .sp_ea_valid, .sp_ea,
		.sp_load, .sp_load_value, .acc_valid, .acc_addr);
	initial forever #10 hclk = ~hclk;
	task automatic chk(input string n, input [34:0] e, input [34:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	always @(negedge hclk) if (mem_en || sp_ea_valid || acc_valid) chk("event", evq.pop_front(), {stack_trap,
		boot_secure_ram_segment_deny, general_secure_ram_segment_deny, mem_addr & {16{mem_en}}, mem_wdata & {16{mem_we}}});
	always @(posedge hclk) if (rd_ph) chk("hrdata", rdq.pop_front(), {3'h0, hrdata});
	task automatic bus(input w, input [31:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		if (!w) rdq.push_back({3'h0, d});
		do @(posedge hclk); while (!hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge hclk); while (!hreadyout);
		chk("hresp", 35'h0, {34'h0, hresp});
		rd_ph <= 0;
		hsel <= 0;
	endtask
	task automatic st(input [2:0] c, input [15:0] v);
		reg [15:0] a, w;
		reg t, b, g;
		a = c == 3'h4 ? sp - 16'h0002 : c == 3'h5 ? v : sp;
		w = c == 3'h0 ? v : c == 3'h1 ? pc[15:0] : c == 3'h2 ? {9'h0, pc[22:16]} : {status_low_byte, ipl3_bit, pc[22:16]};
		t = c < 3'h6 && ((lim_set && a > lim) || a < 16'h0800);
		b = c == 3'h6 && v >= 16'h1000 && v <= 16'h1fff && !exec_in_boot;
		g = c == 3'h6 && v >= 16'h3000 && v <= 16'h3fff && !exec_in_secure;
		if (c < 3'h4) sp = sp + 16'h0002;
		if (c == 3'h4) sp = a;
		if (c == 3'h7) sp = v & 16'hfffe;
		if (c < 3'h7) evq.push_back({t, b, g, c < 3'h5 ? a : 16'h0, c < 3'h4 ? w : 16'h0});
		i_core.op(c, v);
	endtask
	task summarize;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		summarize;
	end
	initial begin
		i = $urandom(44433);
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		bus(0, 32'h1c, 32'h0);
		bus(0, 32'h0, 32'h800);
		for (i = 0; i < 4; i++) begin
			pc <= $urandom;
			status_low_byte <= $urandom;
			ipl3_bit <= $urandom;
			@(posedge hclk);
			st(i[2:0], $urandom);
		end
		repeat (5) st(3'h4, 16'h0);
		st(3'h0, 16'h5a5a);
		st(3'h5, 16'h07fe);
		st(3'h7, 16'h1ffd);
		st(3'h0, 16'h0001);
		bus(1, 32'h4, 32'h1fff);
		lim = 16'h1ffe;
		lim_set = 1;
		// no stack-relative read right after the limit write
		bus(0, 32'h4, 32'h1ffe);
		bus(0, 32'h1c, 32'h3);
		st(3'h4, 16'h0);
		for (i = 0; i < 3; i++) st(3'h0, $urandom);
		st(3'h5, 16'h2000);
		bus(0, 32'h14, 32'h3);
		@(negedge hclk) chk("irq", 35'h0, {34'h0, irq});
		bus(1, 32'h18, 32'h1);
		@(negedge hclk) chk("irq", 35'h1, {34'h0, irq});
		bus(1, 32'h14, 32'h3);
		bus(0, 32'h14, 32'h0);
		@(negedge hclk) chk("irq", 35'h0, {34'h0, irq});
		bus(1, 32'h8, 32'h3);
		bus(1, 32'hc, 32'h1fff_1000);
		bus(1, 32'h10, 32'h3fff_3000);
		for (i = 0; i < 4; i++) begin
			exec_in_boot <= i[0];
			exec_in_secure <= i[1];
			@(posedge hclk);
			st(3'h6, 16'h1ffe);
			st(3'h6, 16'h3000);
			st(3'h6, 16'h2000);
		end
		// both deny events seen in the loop, no stack trap since the clear
		bus(0, 32'h14, 32'hc);
		bus(0, 32'h20, 32'h0);
		bus(1, 32'h0, 32'h0a00);
		sp = 16'h0a00;
		bus(0, 32'h0, 32'h0a00);
		repeat (3) @(posedge hclk);
		// every noted result must have been seen
		chk("pending", 35'h0, evq.size() + rdq.size());
		summarize;
	end
endmodule // slg_stack_guard_test
bind slg_stack_guard slg_guard_checker i_chk (.hclk, .hresetn, .stk_push, .stk_push_kind, .pc, .status_low_byte,
	.ipl3_bit, .stk_pop, .sp_ea_valid, .sp_ea, .acc_valid, .exec_in_boot, .exec_in_secure, .mem_we, .mem_addr,
	.mem_wdata, .stack_pointer_register, .stack_trap, .boot_secure_ram_segment_deny, .general_secure_ram_segment_deny);
